// *** rtl/hs_status_defines.svh ***
// Constants of the hot swap status register bank.
// Assumes inclusion by bare name from the status module.
`ifndef HS_STATUS_DEFINES_SVH
`define HS_STATUS_DEFINES_SVH

// ----------------------------------------------------------------
// Read byte command codes
// ----------------------------------------------------------------
`define CODE_OUTPUT_VOLTAGE_STATUS 8'h7a
`define CODE_OUTPUT_CURRENT_STATUS 8'h7b
`define CODE_INPUT_STATUS 8'h7c
`define CODE_HOT_SWAP_EXTRA_STATUS 8'h80

// ----------------------------------------------------------------
// Reset value of every status byte
// ----------------------------------------------------------------
`define STATUS_RESET 8'h00

// ----------------------------------------------------------------
// Output voltage status bit positions
// ----------------------------------------------------------------
`define VOUT_OV_WARN_BIT 6
`define VOUT_UV_WARN_BIT 5

// ----------------------------------------------------------------
// Output current status bit positions
// ----------------------------------------------------------------
`define IOUT_OC_FAULT_BIT 7
`define IOUT_OC_WARN_BIT 5

// ----------------------------------------------------------------
// Input status bit positions
// ----------------------------------------------------------------
`define VIN_OV_FAULT_BIT 7
`define VIN_OV_WARN_BIT 6
`define VIN_UV_WARN_BIT 5
`define VIN_UV_FAULT_BIT 4
`define PIN_OP_WARN_BIT 0

// ----------------------------------------------------------------
// Hot swap extra status bit positions
// ----------------------------------------------------------------
`define FET_SHORT_BIT 7
`define UV_LEVEL_BIT 6
`define OV_LEVEL_BIT 5
`define INLIM_BIT 3
`define REASON_HI_BIT 2
`define REASON_LO_BIT 1
`define WARN2_BIT 0

// ----------------------------------------------------------------
// Summary nibble positions (status word bits 15 to 12)
// ----------------------------------------------------------------
`define SUM_VOUT_BIT 3
`define SUM_IOUT_BIT 2
`define SUM_INPUT_BIT 1
`define SUM_EXTRA_BIT 0

`endif

// *** rtl/hs_status_pkg.sv ***
// Types shared by the hot swap status register bank.
// Assumes the defines header sits beside it.
package hs_status_pkg;

   // ----------------------------------------------------------------
   // Gate shutdown reason encoding
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      REASON_NONE = 2'b00, // Running or turned off by command
      REASON_OC = 2'b01, // Overcurrent timeout
      REASON_UV = 2'b10, // Input undervoltage on pin
      REASON_OV = 2'b11 // Input overvoltage on pin
   } shutdown_reason_t;

   // ----------------------------------------------------------------
   // Event flags from the power monitor and current limiter
   // ----------------------------------------------------------------
   typedef struct packed {
      logic vout_ov_warn; // Monitor: output overvoltage
      logic vout_uv_warn; // Monitor: output undervoltage
      logic iout_oc_warn; // Monitor: current above warning limit
      logic vin_ov_warn; // Monitor: input overvoltage
      logic vin_uv_warn; // Monitor: input undervoltage
      logic pin_op_warn; // Monitor: input overpower
      logic fet_short_suspect; // FET looks shorted
      logic current_limit_active; // Limiter regulating now
      logic oc_timer_expired; // Limit timer ran out
      logic above_second_threshold; // Current above second threshold
      logic below_second_threshold; // Current below second threshold
   } monitor_events_t;

   // ----------------------------------------------------------------
   // Whole state of the status bank
   // ----------------------------------------------------------------
   typedef struct packed {
      logic vout_ov; // Latched output overvoltage warning
      logic vout_uv; // Latched output undervoltage warning
      logic iout_oc_fault; // Latched overcurrent fault
      logic iout_oc_warn; // Latched overcurrent warning
      logic vin_ov_fault; // Latched pin overvoltage
      logic vin_ov_warn; // Latched input overvoltage warning
      logic vin_uv_warn; // Latched input undervoltage warning
      logic vin_uv_fault; // Latched pin undervoltage
      logic pin_op_warn; // Latched overpower warning
      logic fet_short_suspect; // Latched FET doubt
      logic current_limit_active; // Latched limiting flag
      shutdown_reason_t gate_shutdown_reason; // Latched cause
      logic second_current_warning; // Latched second warning
      logic gate_off_seen; // Gate off level of last cycle
      logic [7:0] rd_data; // Byte returned to the host
      logic rd_ack; // Read answered
      logic rd_err; // Read of unknown code
      logic [3:0] summary; // Pending flags per status byte
   } status_state_t;

endpackage : hs_status_pkg

// *** rtl/hs_status_regs.sv ***
// Hot swap status register bank answering read byte commands.
// Assumes event flags from same-clock monitor logic, async pin levels.
`timescale 1ns/10ps

`include "hs_status_defines.svh"

module hs_status_regs
   import hs_status_pkg::*;
(
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RST_I,
   // Read byte request from the bus engine
   input wire logic READ_I,
   input wire logic [7:0] CODE_I,
   output logic [7:0] DATA_O,
   output logic ACK_O,
   output logic ERR_O,
   // Clear of all latched bits
   input wire logic CLEAR_I,
   // Monitor and limiter events
   input wire monitor_events_t MON_EVENTS_I,
   input wire logic GATE_OFF_I,
   input wire logic SECOND_CURRENT_POLARITY_I,
   // Comparator pins, asynchronous
   input wire logic UV_CMP_PIN_I,
   input wire logic OV_CMP_PIN_I,
   // Summary of pending bytes
   output logic [3:0] SUMMARY_O
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   status_state_t st; // Current state
   status_state_t next_st; // Next state
   logic [1:0] cmp_sync; // Synchronised comparator levels
   logic undervoltage_comparator_level; // UV pin below threshold
   logic overvoltage_comparator_level; // OV pin above threshold
   logic [7:0] vout_byte; // Assembled bytes
   logic [7:0] iout_byte;
   logic [7:0] input_byte;
   logic [7:0] extra_byte;
   logic warn2_hit; // Second threshold crossed as selected
   logic gate_rise; // Gate drive just turned off
   logic oc_shutdown; // Overcurrent timeout with gate down

   // ----------------------------------------------------------------
   // Comparator pin synchroniser
   // ----------------------------------------------------------------
   hs_sync2 #(
      .W(2)
   ) cmp_sync_u (
      .CLK_I(CLK_I),
      .RST_I(RST_I),
      .async_i({UV_CMP_PIN_I, OV_CMP_PIN_I}),
      .sync_o(cmp_sync)
   );

   assign undervoltage_comparator_level = cmp_sync[1];
   assign overvoltage_comparator_level = cmp_sync[0];

   // ----------------------------------------------------------------
   // Event decode
   // ----------------------------------------------------------------
   // Polarity high selects over, low selects under
   assign warn2_hit = SECOND_CURRENT_POLARITY_I ?
      MON_EVENTS_I.above_second_threshold :
      MON_EVENTS_I.below_second_threshold;
   assign gate_rise = GATE_OFF_I && !st.gate_off_seen;
   assign oc_shutdown = MON_EVENTS_I.oc_timer_expired && GATE_OFF_I;

   // ----------------------------------------------------------------
   // Byte assembly from next state and synchronised pin levels; reserved bits zero
   // ----------------------------------------------------------------
   always_comb
   begin
      vout_byte = `STATUS_RESET;
      vout_byte[`VOUT_OV_WARN_BIT] = next_st.vout_ov;
      vout_byte[`VOUT_UV_WARN_BIT] = next_st.vout_uv;
      iout_byte = `STATUS_RESET;
      iout_byte[`IOUT_OC_FAULT_BIT] = next_st.iout_oc_fault;
      iout_byte[`IOUT_OC_WARN_BIT] = next_st.iout_oc_warn;
      input_byte = `STATUS_RESET;
      input_byte[`VIN_OV_FAULT_BIT] = next_st.vin_ov_fault;
      input_byte[`VIN_OV_WARN_BIT] = next_st.vin_ov_warn;
      input_byte[`VIN_UV_WARN_BIT] = next_st.vin_uv_warn;
      input_byte[`VIN_UV_FAULT_BIT] = next_st.vin_uv_fault;
      input_byte[`PIN_OP_WARN_BIT] = next_st.pin_op_warn;
      extra_byte = `STATUS_RESET;
      extra_byte[`FET_SHORT_BIT] = next_st.fet_short_suspect;
      extra_byte[`UV_LEVEL_BIT] = undervoltage_comparator_level;
      extra_byte[`OV_LEVEL_BIT] = overvoltage_comparator_level;
      extra_byte[`INLIM_BIT] = next_st.current_limit_active;
      extra_byte[`REASON_HI_BIT:`REASON_LO_BIT] =
         next_st.gate_shutdown_reason;
      extra_byte[`WARN2_BIT] = next_st.second_current_warning;
   end

   // ----------------------------------------------------------------
   // Next state: latch events, clear on request, answer reads
   // ----------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      // Clear first; a same-cycle event then sets again
      if (CLEAR_I)
      begin
         next_st.vout_ov = 1'b0;
         next_st.vout_uv = 1'b0;
         next_st.iout_oc_fault = 1'b0;
         next_st.iout_oc_warn = 1'b0;
         next_st.vin_ov_fault = 1'b0;
         next_st.vin_ov_warn = 1'b0;
         next_st.vin_uv_warn = 1'b0;
         next_st.vin_uv_fault = 1'b0;
         next_st.pin_op_warn = 1'b0;
         next_st.fet_short_suspect = 1'b0;
         next_st.current_limit_active = 1'b0;
         next_st.gate_shutdown_reason = REASON_NONE;
         next_st.second_current_warning = 1'b0;
      end
      // Output voltage warnings
      if (MON_EVENTS_I.vout_ov_warn)
      begin
         next_st.vout_ov = 1'b1;
      end
      if (MON_EVENTS_I.vout_uv_warn)
      begin
         next_st.vout_uv = 1'b1;
      end
      // Output current fault and warning
      if (oc_shutdown)
      begin
         next_st.iout_oc_fault = 1'b1;
      end
      if (MON_EVENTS_I.iout_oc_warn)
      begin
         next_st.iout_oc_warn = 1'b1;
      end
      // Input pin faults from comparators
      if (overvoltage_comparator_level)
      begin
         next_st.vin_ov_fault = 1'b1;
      end
      if (undervoltage_comparator_level)
      begin
         next_st.vin_uv_fault = 1'b1;
      end
      // Input monitor warnings
      if (MON_EVENTS_I.vin_ov_warn)
      begin
         next_st.vin_ov_warn = 1'b1;
      end
      if (MON_EVENTS_I.vin_uv_warn)
      begin
         next_st.vin_uv_warn = 1'b1;
      end
      if (MON_EVENTS_I.pin_op_warn)
      begin
         next_st.pin_op_warn = 1'b1;
      end
      // Hot swap extra flags
      if (MON_EVENTS_I.fet_short_suspect)
      begin
         next_st.fet_short_suspect = 1'b1;
      end
      if (MON_EVENTS_I.current_limit_active)
      begin
         next_st.current_limit_active = 1'b1;
      end
      if (warn2_hit)
      begin
         next_st.second_current_warning = 1'b1;
      end
      // Reason captured when the gate goes down
      if (gate_rise)
      begin
         if (oc_shutdown)
         begin
            next_st.gate_shutdown_reason = REASON_OC;
         end
         else if (overvoltage_comparator_level)
         begin
            next_st.gate_shutdown_reason = REASON_OV;
         end
         else if (undervoltage_comparator_level)
         begin
            next_st.gate_shutdown_reason = REASON_UV;
         end
         else
         begin
            next_st.gate_shutdown_reason = REASON_NONE;
         end
      end
      next_st.gate_off_seen = GATE_OFF_I;
      // Summary of bytes holding any set bit
      next_st.summary[`SUM_VOUT_BIT] = |vout_byte;
      next_st.summary[`SUM_IOUT_BIT] = |iout_byte;
      next_st.summary[`SUM_INPUT_BIT] = |input_byte;
      next_st.summary[`SUM_EXTRA_BIT] = |extra_byte;
      // Read answer, one cycle after the request
      next_st.rd_ack = READ_I;
      next_st.rd_err = 1'b0;
      next_st.rd_data = `STATUS_RESET;
      if (READ_I)
      begin
         unique case (CODE_I)
            `CODE_OUTPUT_VOLTAGE_STATUS: next_st.rd_data = vout_byte;
            `CODE_OUTPUT_CURRENT_STATUS: next_st.rd_data = iout_byte;
            `CODE_INPUT_STATUS: next_st.rd_data = input_byte;
            `CODE_HOT_SWAP_EXTRA_STATUS: next_st.rd_data = extra_byte;
            // Unknown code answers zero with error
            default: next_st.rd_err = 1'b1;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all from flip-flops
   // ----------------------------------------------------------------
   assign DATA_O = st.rd_data;
   assign ACK_O = st.rd_ack;
   assign ERR_O = st.rd_err;
   assign SUMMARY_O = st.summary;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (RST_I);

   // Read request carrying a given code
   sequence s_read(logic [7:0] code);
      READ_I && CODE_I == code;
   endsequence

   AST_VOUT_READ: assert property (
      s_read(`CODE_OUTPUT_VOLTAGE_STATUS) |=> ACK_O && !ERR_O &&
      DATA_O[7] == 1'b0 && DATA_O[4:0] == 5'h00)
      else $error("output voltage byte reserved bits set");

   AST_VOUT_OV: assert property (
      MON_EVENTS_I.vout_ov_warn |=> st.vout_ov)
      else $error("output overvoltage warning not latched");

   AST_VOUT_UV: assert property (
      MON_EVENTS_I.vout_uv_warn ##0 READ_I &&
      CODE_I == `CODE_OUTPUT_VOLTAGE_STATUS |=> DATA_O[5])
      else $error("output undervoltage warning not reported");

   AST_IOUT_READ: assert property (
      s_read(`CODE_OUTPUT_CURRENT_STATUS) |=> ACK_O &&
      DATA_O[6] == 1'b0 && DATA_O[4:0] == 5'h00 &&
      DATA_O[7] == st.iout_oc_fault)
      else $error("output current byte wrong");

   AST_OC_FAULT_CAUSE: assert property (
      $rose(st.iout_oc_fault) |-> $past(oc_shutdown))
      else $error("overcurrent fault set without timeout and gate off");

   AST_OC_WARN: assert property (
      MON_EVENTS_I.iout_oc_warn |=> st.iout_oc_warn)
      else $error("overcurrent warning not latched");

   AST_INPUT_READ: assert property (
      s_read(`CODE_INPUT_STATUS) |=> ACK_O && DATA_O[3:1] == 3'b000)
      else $error("input byte reserved bits set");

   AST_OV_PIN: assert property (
      overvoltage_comparator_level |=> st.vin_ov_fault)
      else $error("overvoltage pin fault not latched");

   AST_UV_PIN: assert property (
      $rose(UV_CMP_PIN_I) ##1 UV_CMP_PIN_I[*2] |=> st.vin_uv_fault)
      else $error("undervoltage pin fault not latched in time");

   AST_EXTRA_READ: assert property (
      s_read(`CODE_HOT_SWAP_EXTRA_STATUS) |=> ACK_O && !DATA_O[4] &&
      DATA_O[6] == $past(undervoltage_comparator_level) &&
      DATA_O[5] == $past(overvoltage_comparator_level))
      else $error("extra byte wrong");

   AST_INLIM: assert property (
      MON_EVENTS_I.current_limit_active |=> st.current_limit_active)
      else $error("current limit flag not set at once");

   AST_REASON_OC: assert property (
      gate_rise && oc_shutdown |=> st.gate_shutdown_reason == REASON_OC)
      else $error("overcurrent shutdown reason not latched");

   AST_WARN2: assert property (
      !SECOND_CURRENT_POLARITY_I && MON_EVENTS_I.below_second_threshold
      |=> st.second_current_warning)
      else $error("under polarity second warning missed");

   AST_SUMMARY: assert property (
      st.vout_ov && !CLEAR_I |=> SUMMARY_O[`SUM_VOUT_BIT])
      else $error("summary misses pending output voltage bit");

   AST_HOLD: assert property (
      st.vin_ov_warn && !CLEAR_I |=> st.vin_ov_warn)
      else $error("latched bit lost without clear");

endmodule : hs_status_regs

// *** rtl/hs_sync2.sv ***
// Two flip-flop synchroniser for a group of asynchronous levels.
// Assumes the levels change slowly against the clock.
`timescale 1ns/10ps

module hs_sync2 #(
   parameter int W = 2
) (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RST_I,
   // Levels
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);

   // ----------------------------------------------------------------
   // State: first stage read only by second stage
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [W-1:0] meta; // First stage
      logic [W-1:0] stable; // Second stage
   } sync_state_t;

   sync_state_t st; // Current state
   sync_state_t next_st; // Next state

   // Shift chain
   always_comb
   begin
      next_st.meta = async_i;
      next_st.stable = st.meta;
   end

   // State register
   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign sync_o = st.stable;

endmodule : hs_sync2

// *** tb/hs_host_model.sv ***
// Host side model issuing read byte requests to the status bank.
// Assumes the bench calls read_byte and shares the bank clock.
`timescale 1ns/10ps

module hs_host_model
(
   // Clock
   input wire logic clk_i,
   // Answer from the bank
   input wire logic ack_i,
   input wire logic err_i,
   input wire logic [7:0] data_i,
   // Request to the bank
   output logic read_o,
   output logic [7:0] code_o
);
   // ----------------------------------------------------------------
   // Idle levels
   // ----------------------------------------------------------------
   initial
   begin
      read_o = 1'b0;
      code_o = 8'h00;
   end

   // ----------------------------------------------------------------
   // One read byte transfer, answer awaited under a bound
   // ----------------------------------------------------------------
   task automatic read_byte(input logic [7:0] c, output logic [7:0] d,
                            output logic e);
      int n;
      d = 8'hxx;
      e = 1'bx;
      @(posedge clk_i);
      read_o <= 1'b1;
      code_o <= c;
      @(posedge clk_i);
      read_o <= 1'b0;
      // Released code shows no stale value
      code_o <= ~c;
      // Answer taken at the rising edge where it is sampled high
      for (n = 0; n < 3; n++)
      begin
         @(posedge clk_i);
         if (ack_i === 1'b1)
         begin
            d = data_i;
            e = err_i;
            break;
         end
      end
   endtask : read_byte
endmodule : hs_host_model

// *** tb/test_hot_swap_status_registers.sv ***
// Self-checking bench for the hot swap status register bank.
// Assumes the host model beside it and the bank package compiled first.
`timescale 1ns/10ps

module test_hot_swap_status_registers;
   import hs_status_pkg::*;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic clk; // Bench clock
   logic rst; // Async reset
   logic rd; // Read strobe from host
   logic [7:0] code; // Command code from host
   logic [7:0] data; // Answered byte
   logic ack; // Answer strobe
   logic err; // Unknown code flag
   logic clr; // Clear strobe
   monitor_events_t mon; // Event flags
   logic gate_off; // Gate disabled level
   logic pol; // Second warning polarity
   logic uv_pin; // UV comparator pin
   logic ov_pin; // OV comparator pin
   logic [3:0] summary; // Pending byte flags
   int error_cnt = 0; // Mismatches
   int n_compared = 0; // Comparisons

   always #20 clk = ~clk;

   hs_status_regs dut_u (.CLK_I(clk), .RST_I(rst), .READ_I(rd),
      .CODE_I(code), .DATA_O(data), .ACK_O(ack), .ERR_O(err),
      .CLEAR_I(clr), .MON_EVENTS_I(mon), .GATE_OFF_I(gate_off),
      .SECOND_CURRENT_POLARITY_I(pol), .UV_CMP_PIN_I(uv_pin),
      .OV_CMP_PIN_I(ov_pin), .SUMMARY_O(summary));

   hs_host_model host_u (.clk_i(clk), .ack_i(ack), .err_i(err),
      .data_i(data), .read_o(rd), .code_o(code));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic rd_chk(input logic [7:0] c, input logic [7:0] exp,
                         input logic exp_err);
      logic [7:0] d;
      logic e;
      host_u.read_byte(c, d, e);
      check(d, exp);
      check({7'h00, e}, {7'h00, exp_err});
      // Answer stands one cycle, then the byte falls back to zero
      @(negedge clk);
      check({ack, err, 6'h00}, 8'h00);
      check(data, 8'h00);
   endtask : rd_chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   task automatic pulse(input logic [10:0] m, input logic g);
      @(posedge clk);
      mon <= monitor_events_t'(m);
      gate_off <= g;
      @(posedge clk);
      mon <= '0;
      gate_off <= 1'b0;
      tick(1);
   endtask : pulse

   task automatic clear_all;
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      tick(1);
   endtask : clear_all

   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      logic [7:0] codes [4] = '{8'h7a, 8'h7b, 8'h7c, 8'h80};
      foreach (codes[i])
         rd_chk(codes[i], 8'h00, 1'b0);
      rd_chk(8'h7d, 8'h00, 1'b1);
      @(negedge clk);
      check({4'h0, summary}, 8'h00);
      $display("test reset done");
   endtask : t_reset

   task automatic t_events;
      logic [10:0] m [8] = '{11'h400, 11'h200, 11'h100, 11'h080,
                             11'h040, 11'h020, 11'h010, 11'h008};
      logic [7:0] c [8] = '{8'h7a, 8'h7a, 8'h7b, 8'h7c,
                            8'h7c, 8'h7c, 8'h80, 8'h80};
      logic [7:0] x [8] = '{8'h40, 8'h20, 8'h20, 8'h40,
                            8'h20, 8'h01, 8'h80, 8'h08};
      logic [3:0] s [8] = '{4'h8, 4'h8, 4'h4, 4'h2,
                            4'h2, 4'h2, 4'h1, 4'h1};
      foreach (m[i])
      begin
         pulse(m[i], 1'b0);
         rd_chk(c[i], x[i], 1'b0);
         rd_chk(c[i], x[i], 1'b0);
         @(negedge clk);
         check({4'h0, summary}, {4'h0, s[i]});
         clear_all();
         rd_chk(c[i], 8'h00, 1'b0);
      end
      // Event arriving in the clear cycle keeps its bit
      @(posedge clk);
      clr <= 1'b1;
      mon <= monitor_events_t'(11'h400);
      @(posedge clk);
      clr <= 1'b0;
      mon <= '0;
      rd_chk(8'h7a, 8'h40, 1'b0);
      clear_all();
      $display("test events done");
   endtask : t_events

   task automatic t_oc;
      pulse(11'h004, 1'b0);
      rd_chk(8'h7b, 8'h00, 1'b0);
      pulse(11'h004, 1'b1);
      rd_chk(8'h7b, 8'h80, 1'b0);
      rd_chk(8'h80, 8'h02, 1'b0);
      clear_all();
      rd_chk(8'h80, 8'h00, 1'b0);
      $display("test overcurrent done");
   endtask : t_oc

   task automatic t_pin(input logic uv, input logic [7:0] live,
                        input logic [7:0] fault, input logic [1:0] rsn);
      @(posedge clk);
      uv_pin <= uv;
      ov_pin <= ~uv;
      tick(4);
      @(posedge clk);
      gate_off <= 1'b1;
      tick(2);
      rd_chk(8'h80, live | {5'h00, rsn, 1'b0}, 1'b0);
      @(posedge clk);
      uv_pin <= 1'b0;
      ov_pin <= 1'b0;
      gate_off <= 1'b0;
      tick(4);
      rd_chk(8'h80, {5'h00, rsn, 1'b0}, 1'b0);
      rd_chk(8'h7c, fault, 1'b0);
      clear_all();
      rd_chk(8'h7c, 8'h00, 1'b0);
      $display("test pin %0d done", uv);
   endtask : t_pin

   task automatic t_warn2;
      for (int p = 0; p < 2; p++)
      begin
         @(posedge clk);
         pol <= p[0];
         pulse(p[0] ? 11'h001 : 11'h002, 1'b0);
         rd_chk(8'h80, 8'h00, 1'b0);
         pulse(p[0] ? 11'h002 : 11'h001, 1'b0);
         rd_chk(8'h80, 8'h01, 1'b0);
         clear_all();
      end
      $display("test second warning done");
   endtask : t_warn2

   // Reset in mid-run drops latched bits and outputs
   task automatic t_rerun;
      pulse(11'h420, 1'b0);
      @(posedge clk);
      rst <= 1'b1;
      tick(3);
      rst <= 1'b0;
      @(negedge clk);
      check({ack, err, 2'b00, summary}, 8'h00);
      rd_chk(8'h7a, 8'h00, 1'b0);
      rd_chk(8'h7c, 8'h00, 1'b0);
      $display("test reset rerun done");
   endtask : t_rerun

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      clr = 1'b0;
      mon = '0;
      gate_off = 1'b0;
      pol = 1'b0;
      uv_pin = 1'b0;
      ov_pin = 1'b0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_events();
      t_oc();
      t_pin(1'b1, 8'h40, 8'h10, 2'b10);
      t_pin(1'b0, 8'h20, 8'h80, 2'b11);
      t_warn2();
      t_rerun();
      report_and_stop();
   end

   initial
   begin
      repeat (6000) @(posedge clk);
      error_cnt++;
      report_and_stop();
   end
endmodule : test_hot_swap_status_registers
